// >>> design/acs_seq_top.sv
/*
 Conversion sequencer with APB register slave, sleep-started
 conversion and completion interrupt. Assumes APB signals and all
 inputs synchronous to sys_clk; the analog side holds its input on
 sample_hold and answers each trial code on cmp_above in the same
 cycle.
*/
`timescale 1ns/100ps
`include "acs_map.svh"
module acs_seq_top (
    input logic sys_clk,
    input logic rst,
    input logic [7:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic auto_trig,
    input logic [2:0] sleep_mode,
    input logic cpu_halted,
    input logic cmp_above,
    output logic [9:0] dac_code,
    output logic [4:0] mux_sel,
    output logic [1:0] ref_sel,
    output logic sample_hold,
    output logic irq
);
    acs_pkg::acs_seq_t s_r;
    acs_pkg::acs_seq_t s_nxt;
    acs_conv_if cif();

    logic wr;
    logic halt_rise;
    logic sleep_req;
    logic sw_req;
    logic trig_req;
    logic req;
    logic done;
    logic [5:0] hc_inc;
    logic [5:0] hc_ofs;
    logic [1:0] st_set;
    logic [1:0] st_clr;
    logic busy;

    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = psel && penable && pwrite && (paddr == ofs);
    endfunction : wr_at

    acs_clkdiv u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .cif(cif)
    );

    acs_sar u_sar (
        .sys_clk(sys_clk),
        .rst(rst),
        .cif(cif)
    );

    assign cif.div = s_r.div;
    assign cif.cmp_above = cmp_above;
    assign busy = (s_r.st != acs_pkg::ACS_IDLE);
    assign wr = psel && penable && pwrite;
    assign hc_inc = s_r.hc + 6'h01;
    assign hc_ofs = hc_inc - s_r.smp;
    assign done = (s_r.st == acs_pkg::ACS_CONV) && cif.half_tick
        && (hc_inc == s_r.len);
    assign cif.sample = (s_r.st == acs_pkg::ACS_CONV) && cif.half_tick
        && (hc_inc == s_r.smp);
    // One step per converter cycle after the hold instant; the eleventh step decides nothing
    assign cif.step = (s_r.st == acs_pkg::ACS_CONV) && cif.half_tick
        && (hc_inc > s_r.smp) && !hc_ofs[0] && !done;

    // Halt edge only: a wake-up leaves the converter alone until the
    // next sleep entry, even while the CPU still reads as halted
    assign halt_rise = cpu_halted && !s_r.halt_d;
    assign sleep_req = halt_rise && s_r.en
        && (sleep_mode == `ACS_SLP_IDLE
        || sleep_mode == `ACS_SLP_NR);
    assign sw_req = wr_at(`ACS_CTRL_OFS) && pwdata[`ACS_CTRL_START]
        && pwdata[`ACS_CTRL_EN];
    assign trig_req = s_r.en && auto_trig
        && (s_r.mode == `ACS_MODE_AUTO);
    assign req = sw_req || trig_req || sleep_req;

    assign pready = 1'b1;
    assign prdata = s_r.prdata;
    assign pslverr = s_r.perr;
    assign dac_code = cif.trial;
    assign mux_sel = s_r.chan;
    assign ref_sel = s_r.refs;
    assign sample_hold = s_r.sh;
    assign irq = |(s_r.status & s_r.irqen);

    always_comb begin
        s_nxt = s_r;
        s_nxt.sh = cif.sample;
        s_nxt.halt_d = cpu_halted;
        st_set = 2'h0;
        st_clr = 2'h0;
        if (req && (busy || !(s_r.en || sw_req))) begin
            st_set[`ACS_ST_IGN] = 1'b1;
        end
        case (s_r.st)
            acs_pkg::ACS_IDLE: begin
                if (req) begin
                    s_nxt.st = acs_pkg::ACS_WAIT;
                    s_nxt.pauto = trig_req && !sw_req;
                end
            end
            acs_pkg::ACS_WAIT: begin
                if (cif.ck_rise) begin
                    s_nxt.st = acs_pkg::ACS_CONV;
                    s_nxt.hc = 6'h00;
                    s_nxt.first = 1'b0;
                    // Later channel writes cannot reach this conversion
                    s_nxt.chan = s_r.chan_sw;
                    s_nxt.diff = |s_r.chan_sw[4:3];
                    if (s_r.first) begin
                        s_nxt.len = `ACS_FIRST_LEN;
                        s_nxt.smp = `ACS_FIRST_SMP;
                    end else if (|s_r.chan_sw[4:3]) begin
                        // Long form moves the hold one full cycle on
                        if (cif.ck2) begin
                            s_nxt.len = `ACS_DIFL_LEN;
                            s_nxt.smp = `ACS_DIFL_SMP;
                        end else begin
                            s_nxt.len = `ACS_DIFS_LEN;
                            s_nxt.smp = `ACS_DIFS_SMP;
                        end
                    end else if (s_r.pauto) begin
                        s_nxt.len = `ACS_AUTO_LEN;
                        s_nxt.smp = `ACS_AUTO_SMP;
                    end else begin
                        s_nxt.len = `ACS_NORM_LEN;
                        s_nxt.smp = `ACS_NORM_SMP;
                    end
                end
            end
            acs_pkg::ACS_CONV: begin
                // A wake-up does not stop a running conversion
                if (cif.half_tick) begin
                    s_nxt.hc = hc_inc;
                end
                if (done) begin
                    s_nxt.result = cif.trial;
                    st_set[`ACS_ST_DONE] = 1'b1;
                    if (s_r.mode == `ACS_MODE_FREE) begin
                        s_nxt.st = acs_pkg::ACS_WAIT;
                        s_nxt.pauto = 1'b0;
                    end else begin
                        s_nxt.st = acs_pkg::ACS_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.st = acs_pkg::ACS_IDLE;
            end
        endcase
        // Only software changes the enable; sleep never touches it
        if (wr_at(`ACS_CTRL_OFS)) begin
            s_nxt.en = pwdata[`ACS_CTRL_EN];
            s_nxt.mode = pwdata[`ACS_CTRL_MODE +: 2];
            s_nxt.refs = pwdata[`ACS_CTRL_REF +: 2];
            s_nxt.div = pwdata[`ACS_CTRL_DIV +: 3];
            if (pwdata[`ACS_CTRL_EN] && !s_r.en) begin
                s_nxt.first = 1'b1;
            end
            if (!pwdata[`ACS_CTRL_EN]) begin
                s_nxt.st = acs_pkg::ACS_IDLE;
            end
        end
        if (wr_at(`ACS_CHAN_OFS)) begin
            s_nxt.chan_sw = pwdata[4:0];
        end
        if (wr_at(`ACS_IRQEN_OFS)) begin
            s_nxt.irqen = pwdata[1:0];
        end
        if (wr_at(`ACS_CLEAR_OFS)) begin
            st_clr = pwdata[1:0];
        end
        // An event in the clearing cycle survives the clear
        s_nxt.status = (s_r.status & ~st_clr) | st_set;
        if (psel && !penable) begin
            s_nxt.perr = 1'b0;
            case (paddr)
                `ACS_CTRL_OFS: s_nxt.prdata = {23'h0, s_r.div, s_r.refs,
                    s_r.mode, busy, s_r.en};
                `ACS_CHAN_OFS: s_nxt.prdata = {27'h0, s_r.chan_sw};
                `ACS_RESULT_OFS: s_nxt.prdata = {22'h0, s_r.result};
                `ACS_STATUS_OFS: s_nxt.prdata = {30'h0, s_r.status};
                `ACS_CLEAR_OFS: s_nxt.prdata = 32'h0;
                `ACS_IRQEN_OFS: s_nxt.prdata = {30'h0, s_r.irqen};
                `ACS_STATE_OFS: s_nxt.prdata = {23'h0, s_r.first,
                    cif.ck2, s_r.diff, s_r.chan, busy};
                default: begin
                    s_nxt.prdata = 32'h0;
                    s_nxt.perr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= acs_pkg::ACS_IDLE;
            s_r.div <= `ACS_DIV_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    logic conv_entry;
    assign conv_entry = (s_r.st == acs_pkg::ACS_WAIT) && cif.ck_rise
        && !(wr_at(`ACS_CTRL_OFS) && !pwdata[`ACS_CTRL_EN]);

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_first_timing: assert property (
        conv_entry && s_r.first |=> s_r.len == `ACS_FIRST_LEN
        && s_r.smp == `ACS_FIRST_SMP && s_r.hc == 6'h00)
        else $error("First conversion timing wrong");

    a_norm_timing: assert property (
        conv_entry && !s_r.first && !(|s_r.chan_sw[4:3]) |=>
        (s_r.pauto ? (s_r.len == `ACS_AUTO_LEN && s_r.smp == `ACS_AUTO_SMP)
        : (s_r.len == `ACS_NORM_LEN && s_r.smp == `ACS_NORM_SMP)))
        else $error("Single ended timing wrong");

    a_diff_timing: assert property (
        conv_entry && !s_r.first && (|s_r.chan_sw[4:3]) |=>
        (s_r.len == `ACS_DIFS_LEN && s_r.smp == `ACS_DIFS_SMP)
        || (s_r.len == `ACS_DIFL_LEN && s_r.smp == `ACS_DIFL_SMP))
        else $error("Differential timing wrong");

    a_diff_phase: assert property (
        cif.sample && s_r.diff && !s_r.first |-> cif.ck2 ##1 sample_hold)
        else $error("Differential hold off phase");

    a_chan_held: assert property (
        s_r.st == acs_pkg::ACS_CONV && $past(s_r.st) == acs_pkg::ACS_CONV
        |-> $stable(s_r.chan))
        else $error("Channel changed during conversion");

    a_free_restart: assert property (
        done && s_r.mode == `ACS_MODE_FREE && !wr |=>
        s_r.st == acs_pkg::ACS_WAIT ##[1:17] s_r.st == acs_pkg::ACS_CONV)
        else $error("Free running did not restart");

    a_result_store: assert property (
        done |=> s_r.status[`ACS_ST_DONE] && s_r.result == $past(cif.trial))
        else $error("Result or flag not stored");

    a_sleep_start: assert property (
        sleep_req && !busy && !wr |=>
        s_r.st == acs_pkg::ACS_WAIT ##[1:17] s_r.st == acs_pkg::ACS_CONV)
        else $error("Sleep entry did not start conversion");

    a_irq_raise: assert property (
        done && s_r.irqen[`ACS_ST_DONE] && !wr |=> irq [*1] ##0 busy == (
        s_r.mode == `ACS_MODE_FREE))
        else $error("Completion did not raise interrupt");

    a_en_kept: assert property (
        !wr |=> s_r.en == $past(s_r.en))
        else $error("Enable changed without a write");

    c_first_done: cover property (s_r.first ##1 !s_r.first ##[1:60] done);
    c_diff_long: cover property (conv_entry && !s_r.first
        && (|s_r.chan_sw[4:3]) && cif.ck2);
    c_free_run: cover property (done && s_r.mode == `ACS_MODE_FREE);
    c_sleep_conv: cover property (sleep_req && !busy);
endmodule : acs_seq_top

// >>> pkg/acs_map.svh
/*
 Register offsets, field positions, reset values and conversion timing
 counts of the conversion sequencer. Assumes sequence timing is counted
 in half periods of the converter clock.
*/
// Overview of operation
// - First conversion: 25 cycles, sample at 13.5
// - Normal 13 cycles/1.5; auto 13.5/2
// - Differential: 13 or 14 cycles, sample 1.5/2.5
// - Differential sampling at fixed half-rate clock phase, except the first conversion after enable
// - Single mode captures channel at conversion start
// - Free running restarts; new channel affects next
// - Reference: supply, internal 2.56V, external pin
// - Input above reference gives full scale 0x3FF
// - Idle or noise-reduction sleep entry with converter enabled starts conversion
// - Sleep conversion completion raises waking interrupt
// - Early wake: conversion continues, interrupt at end
// - Stay active until a new sleep entry
// - Other sleep modes leave enable unchanged
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

`define ACS_CTRL_OFS 8'h00
`define ACS_CHAN_OFS 8'h04
`define ACS_RESULT_OFS 8'h08
`define ACS_STATUS_OFS 8'h0C
`define ACS_CLEAR_OFS 8'h10
`define ACS_IRQEN_OFS 8'h14
`define ACS_STATE_OFS 8'h18

`define ACS_CTRL_EN 0
`define ACS_CTRL_START 1
`define ACS_CTRL_MODE 2
`define ACS_CTRL_REF 4
`define ACS_CTRL_DIV 6

`define ACS_MODE_SINGLE 2'h0
`define ACS_MODE_FREE 2'h1
`define ACS_MODE_AUTO 2'h2

`define ACS_REF_EXT 2'h0
`define ACS_REF_SUP 2'h1
`define ACS_REF_INT 2'h3

`define ACS_SLP_IDLE 3'h0
`define ACS_SLP_NR 3'h1

`define ACS_ST_DONE 0
`define ACS_ST_IGN 1

`define ACS_DIV_RST 3'h1
`define ACS_SAR_MSB 10'h200
`define ACS_FULL_SCALE 10'h3FF

// Half periods of the converter clock
`define ACS_FIRST_LEN 6'h32
`define ACS_FIRST_SMP 6'h1B
`define ACS_NORM_LEN 6'h1A
`define ACS_NORM_SMP 6'h03
`define ACS_AUTO_LEN 6'h1B
`define ACS_AUTO_SMP 6'h04
`define ACS_DIFS_LEN 6'h1A
`define ACS_DIFS_SMP 6'h03
`define ACS_DIFL_LEN 6'h1C
`define ACS_DIFL_SMP 6'h05

`endif

// >>> pkg/acs_pkg.sv
/*
 Types of the conversion sequencer: state encoding and the state
 records of each module. Assumes nothing of its surroundings.
*/
package acs_pkg;
    typedef enum logic [1:0] {ACS_IDLE, ACS_WAIT, ACS_CONV} acs_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic ck;
        logic ck2;
    } acs_div_t;

    typedef struct packed {
        logic [9:0] trial;
        logic [9:0] mask;
        logic all_hi;
    } acs_sar_t;

    typedef struct packed {
        acs_state_t st;
        logic en;
        logic first;
        logic pauto;
        logic diff;
        logic [5:0] hc;
        logic [5:0] len;
        logic [5:0] smp;
        logic [4:0] chan;
        logic [4:0] chan_sw;
        logic [9:0] result;
        logic [1:0] status;
        logic [1:0] irqen;
        logic [1:0] mode;
        logic [1:0] refs;
        logic [2:0] div;
        logic halt_d;
        logic sh;
        logic [31:0] prdata;
        logic perr;
    } acs_seq_t;
endpackage : acs_pkg

// >>> pkg/acs_conv_if.sv
/*
 Internal carrier between the sequencer, the converter clock divider
 and the approximation register. Assumes one clock, sys_clk.
*/
`timescale 1ns/100ps
interface acs_conv_if;
    logic [2:0] div;
    logic half_tick;
    logic ck_rise;
    logic ck2;
    logic sample;
    logic step;
    logic cmp_above;
    logic [9:0] trial;

    modport div_mp(input div, output half_tick, output ck_rise,
        output ck2);
    modport sar_mp(input sample, input step, input cmp_above,
        output trial);
endinterface : acs_conv_if

// >>> design/acs_clkdiv.sv
/*
 Converter clock divider: half period of div+1 sys_clk cycles, a
 pulse per half period, and the half-rate conversion clock level.
 Assumes div is quasi-static while converting.
*/
`timescale 1ns/100ps
module acs_clkdiv (
    input logic sys_clk,
    input logic rst,
    acs_conv_if.div_mp cif
);
    acs_pkg::acs_div_t s_r;
    acs_pkg::acs_div_t s_nxt;
    logic tick;

    assign tick = (s_r.cnt >= cif.div);
    assign cif.half_tick = tick;
    assign cif.ck_rise = tick & ~s_r.ck;
    assign cif.ck2 = s_r.ck2;

    always_comb begin
        s_nxt = s_r;
        s_nxt.cnt = tick ? 3'h0 : s_r.cnt + 3'h1;
        s_nxt.ck = s_r.ck ^ tick;
        // Half-rate clock moves on the falling converter edge
        s_nxt.ck2 = s_r.ck2 ^ (tick & s_r.ck);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : acs_clkdiv

// >>> design/acs_sar.sv
/*
 Successive approximation register: one decision per step for the first ten steps, from the
 comparator of the analog side. Assumes cmp_above is high while the
 held input is above the trial code.
*/
`timescale 1ns/100ps
`include "acs_map.svh"
module acs_sar (
    input logic sys_clk,
    input logic rst,
    acs_conv_if.sar_mp cif
);
    acs_pkg::acs_sar_t s_r;
    acs_pkg::acs_sar_t s_nxt;
    logic [9:0] kept;

    assign cif.trial = s_r.trial;

    always_comb begin
        s_nxt = s_r;
        kept = cif.cmp_above ? s_r.trial : (s_r.trial & ~s_r.mask);
        if (cif.sample) begin
            s_nxt.trial = `ACS_SAR_MSB;
            s_nxt.mask = `ACS_SAR_MSB;
            s_nxt.all_hi = 1'b1;
        end else if (cif.step && (s_r.mask != 10'h000)) begin
            // Input above reference keeps every bit: full scale
            s_nxt.trial = kept | (s_r.mask >> 1);
            s_nxt.mask = s_r.mask >> 1;
            s_nxt.all_hi = s_r.all_hi & cif.cmp_above;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    a_full_scale: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.mask == 10'h000 && s_r.all_hi && $fell(|s_r.mask))
        |-> s_r.trial == `ACS_FULL_SCALE)
        else $error("Saturated input did not give full scale");
endmodule : acs_sar

// >>> dv/acs_analog_model.sv
/*
 Analog side model: channel levels in millivolts, a held sample and
 the comparator. Assumes one sample_hold pulse per conversion.
*/
`timescale 1ns/100ps
module acs_analog_model #(
    parameter int VREF_SUP = 5000,
    parameter int VREF_EXT = 3300
) (
    input logic sys_clk,
    input logic [15:0] lvl [32],
    input logic [9:0] dac_code,
    input logic [4:0] mux_sel,
    input logic [1:0] ref_sel,
    input logic sample_hold,
    output logic cmp_above
);
    int vref;
    int code;
    int held_r;

    always_comb begin
        case (ref_sel)
            2'h1: vref = VREF_SUP;
            2'h3: vref = 2560;
            default: vref = VREF_EXT;
        endcase
        // Above the reference the held value beats every trial code
        code = (lvl[mux_sel] >= vref) ? 1024 :
            lvl[mux_sel] * 1024 / vref;
    end

    always_ff @(posedge sys_clk) begin
        if (sample_hold) begin
            held_r <= code;
        end
    end

    assign cmp_above = ((sample_hold ? code : held_r) > int'(dac_code));
endmodule : acs_analog_model

// >>> dv/testbench.sv
/*
 Self-checking testbench of the conversion sequencer: APB master
 tasks, analog model on the far side, sleep control driven here.
 Assumes the register map of acs_map.svh and a 40 MHz sys_clk.
*/
`timescale 1ns/100ps
`include "acs_map.svh"
module testbench;
    localparam int VSUP = 5000;
    localparam int VEXT = 3300;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0;
    logic auto_trig = 1'h0;
    logic [2:0] sleep_mode = 3'h0;
    logic cpu_halted = 1'h0;
    logic [15:0] lvl [32];
    logic [31:0] prdata;
    logic pready, pslverr, cmp_above, sample_hold, irq;
    logic [9:0] dac_code;
    logic [4:0] mux_sel;
    logic [1:0] ref_sel;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    acs_seq_top dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .auto_trig(auto_trig),
        .sleep_mode(sleep_mode), .cpu_halted(cpu_halted),
        .cmp_above(cmp_above), .dac_code(dac_code), .mux_sel(mux_sel),
        .ref_sel(ref_sel), .sample_hold(sample_hold), .irq(irq));

    acs_analog_model #(.VREF_SUP(VSUP), .VREF_EXT(VEXT)) analog (
        .sys_clk(sys_clk), .lvl(lvl), .dac_code(dac_code),
        .mux_sel(mux_sel), .ref_sel(ref_sel),
        .sample_hold(sample_hold), .cmp_above(cmp_above));

    task automatic end_of_test;
        $display("TB: checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, got);
        check_count++;
        if (got !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, got);
        end
    endtask : chk

    task automatic chkr(input string nm, input int lo, hi, v);
        check_count++;
        if (v < lo || v > hi) begin
            n_fail++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
        end
    endtask : chkr

    // Setup and access phases, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        @(posedge sys_clk);
        while (pready !== 1'h1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'h1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'h0, a, 32'h0, q, e);
    endtask : rd

    task automatic chk_irq(input logic e);
        repeat (2) @(posedge sys_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : chk_irq

    // Hold window is checked only when s_lo is above zero
    task automatic meas(input int s_lo, input int s_hi);
        int n;
        int s;
        n = 0;
        s = -1;
        while (irq !== 1'h1 && n < 400) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (sample_hold === 1'h1 && s < 0) s = n;
        end
        chkr("done wait", 1, 399, n);
        if (s_lo > 0) begin
            chkr("hold instant", s_lo, s_hi, s);
            chkr("hold to done", s + 21, s + 25, n);
        end
    endtask : meas

    // The comparator answer convention leaves one code of slack
    task automatic fin(input int mv, input int vr);
        logic [31:0] q;
        int e;
        e = (mv >= vr) ? 1024 : mv * 1024 / vr;
        rd(`ACS_RESULT_OFS, q);
        check_count++;
        if (q !== 32'(e) && q !== 32'(e - 1)) begin
            n_fail++;
            $display("[FAIL] result expected %0d seen %h", e, q);
        end
        rd(`ACS_STATUS_OFS, q);
        chk("done flag", 32'h1, q);
        wr(`ACS_CLEAR_OFS, 32'h3);
        chk_irq(1'h0);
    endtask : fin

    task automatic t_regs;
        logic [31:0] q;
        logic e;
        apb(1'h0, `ACS_CTRL_OFS, 32'h0, q, e);
        chk("ctrl reset", 32'h40, q);
        apb(1'h0, `ACS_STATUS_OFS, 32'h0, q, e);
        chk("status reset", 32'h0, q);
        apb(1'h0, 8'h1C, 32'h0, q, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
    endtask : t_regs

    task automatic t_first;
        wr(`ACS_IRQEN_OFS, 32'h1);
        wr(`ACS_CHAN_OFS, 32'h0);
        wr(`ACS_CTRL_OFS, 32'h13);
        meas(28, 33);
        fin(1000, VSUP);
        wr(`ACS_CTRL_OFS, 32'h13);
        meas(4, 9);
        fin(1000, VSUP);
        wr(`ACS_CTRL_OFS, 32'h19);
        @(posedge sys_clk);
        auto_trig <= 1'h1;
        @(posedge sys_clk);
        auto_trig <= 1'h0;
        meas(4, 11);
        fin(1000, VSUP);
    endtask : t_first

    task automatic t_diff;
        wr(`ACS_CHAN_OFS, 32'h8);
        wr(`ACS_CTRL_OFS, 32'h13);
        meas(4, 11);
        wr(`ACS_CLEAR_OFS, 32'h3);
        for (int k = 0; k < 3; k++) begin
            repeat (k) @(posedge sys_clk);
            wr(`ACS_CTRL_OFS, 32'h13);
            meas(4, 11);
            fin(1800, VSUP);
        end
    endtask : t_diff

    task automatic t_chan;
        wr(`ACS_CHAN_OFS, 32'h1);
        wr(`ACS_CTRL_OFS, 32'h13);
        wr(`ACS_CHAN_OFS, 32'h2);
        meas(0, 0);
        fin(1100, VSUP);
        wr(`ACS_CTRL_OFS, 32'h13);
        meas(0, 0);
        fin(1200, VSUP);
        wr(`ACS_CHAN_OFS, 32'h1);
        wr(`ACS_CTRL_OFS, 32'h17);
        meas(4, 9);
        wr(`ACS_CHAN_OFS, 32'h2);
        fin(1100, VSUP);
        meas(0, 0);
        fin(1100, VSUP);
        meas(0, 0);
        fin(1200, VSUP);
        wr(`ACS_CTRL_OFS, 32'h0);
    endtask : t_chan

    task automatic t_ref;
        logic [1:0] rs [3] = '{2'h1, 2'h3, 2'h0};
        int vs [3] = '{VSUP, 2560, VEXT};
        wr(`ACS_CHAN_OFS, 32'h3);
        for (int i = 0; i < 3; i++) begin
            wr(`ACS_CTRL_OFS, {26'h0, rs[i], 4'h3});
            // The select register loads at this edge: look once it settled
            #1;
            chk("ref sel", {30'h0, rs[i]}, {30'h0, ref_sel});
            meas(0, 0);
            wr(`ACS_CLEAR_OFS, 32'h3);
            wr(`ACS_CTRL_OFS, {26'h0, rs[i], 4'h3});
            meas(0, 0);
            fin(1300, vs[i]);
        end
        // Saturation is a single-ended property: channel 7, raised level
        lvl[7] = 16'h1004;
        wr(`ACS_CHAN_OFS, 32'h7);
        wr(`ACS_CTRL_OFS, 32'h33);
        meas(0, 0);
        wr(`ACS_CLEAR_OFS, 32'h3);
        wr(`ACS_CTRL_OFS, 32'h33);
        meas(0, 0);
        fin(4100, 2560);
    endtask : t_ref

    task automatic t_sleep;
        logic [31:0] q;
        wr(`ACS_CHAN_OFS, 32'h0);
        wr(`ACS_CTRL_OFS, 32'h11);
        for (int m = 0; m < 2; m++) begin
            @(posedge sys_clk);
            sleep_mode <= 3'(m);
            cpu_halted <= 1'h1;
            meas(3, 12);
            cpu_halted <= 1'h0;
            fin(1000, VSUP);
        end
        @(posedge sys_clk);
        cpu_halted <= 1'h1;
        repeat (5) @(posedge sys_clk);
        cpu_halted <= 1'h0;
        meas(0, 0);
        fin(1000, VSUP);
        for (int m = 2; m < 8; m++) begin
            @(posedge sys_clk);
            sleep_mode <= 3'(m);
            cpu_halted <= 1'h1;
            repeat (60) @(posedge sys_clk);
            cpu_halted <= 1'h0;
            chk_irq(1'h0);
            rd(`ACS_CTRL_OFS, q);
            chk("enable kept", 32'h11, q);
        end
        wr(`ACS_CTRL_OFS, 32'h10);
    endtask : t_sleep

    task automatic t_irq;
        logic [31:0] q;
        wr(`ACS_IRQEN_OFS, 32'h0);
        // Divider 1 and a fresh enable: a long first conversion
        wr(`ACS_CTRL_OFS, 32'h53);
        wr(`ACS_CTRL_OFS, 32'h53);
        repeat (140) @(posedge sys_clk);
        chk_irq(1'h0);
        rd(`ACS_STATUS_OFS, q);
        chk("status", 32'h3, q);
        wr(`ACS_IRQEN_OFS, 32'h1);
        chk_irq(1'h1);
        wr(`ACS_CLEAR_OFS, 32'h1);
        chk_irq(1'h0);
        wr(`ACS_IRQEN_OFS, 32'h3);
        chk_irq(1'h1);
        wr(`ACS_CLEAR_OFS, 32'h2);
        chk_irq(1'h0);
    endtask : t_irq

    initial begin
        foreach (lvl[i]) lvl[i] = 16'(1000 + 100 * i);
        repeat (6) @(posedge sys_clk);
        rst <= 1'h0;
        t_regs();
        t_first();
        t_diff();
        t_chan();
        t_ref();
        t_sleep();
        t_irq();
        end_of_test();
    end
endmodule : testbench
